// [spi_channel_defines.svh]
// offsets, field positions, reset values and counts of the serial channel
`ifndef SPI_CHANNEL_DEFINES_SVH
`define SPI_CHANNEL_DEFINES_SVH

// register indexes, byte address is four times the index
`define IDX_SERIAL_STATUS 18'h04320
`define IDX_SERIAL_TX_BUFFER 18'h04322
`define IDX_SERIAL_RX_BUFFER 18'h04324
`define IDX_SERIAL_CONTROL 18'h04326
`define IDX_EVENT_STATUS 18'h04328
`define IDX_EVENT_MASK 18'h0432a

// serial_status fields
`define ST_BUSY_BIT 2
`define ST_RX_FULL_BIT 1
`define ST_TX_EMPTY_BIT 0

// serial_control fields
`define CTL_CLK_SRC_BIT 9
`define CTL_ORDER_BIT 8
`define CTL_RX_IE_BIT 5
`define CTL_TX_IE_BIT 4
`define CTL_PHASE_BIT 3
`define CTL_POLARITY_BIT 2
`define CTL_ROLE_BIT 1
`define CTL_ENABLE_BIT 0
`define CTL_WIDTH 10
`define CTL_WRITE_MASK 10'h33f

// event status / mask fields
`define EV_TX_EMPTY_BIT 0
`define EV_RX_FULL_BIT 1
`define EV_OVERRUN_BIT 2
`define EV_WIDTH 3

// reset values
`define CTL_RESET 10'h000
`define TX_BYTE_RESET 8'h00
`define RX_BYTE_RESET 8'h00
`define TX_EMPTY_RESET 1'b1
`define EV_RESET 3'h0
`define SYNC_RESET 4'h4

// peripheral clock divided by four: one half period is two cycles
`define DIV_LAST 2'h1
`define LAST_BIT 3'h7
`define LAST_EDGE 4'hf

`endif

// [spi_channel_pkg.sv]
// types shared by the serial channel modules
package spi_channel_pkg;

   typedef enum logic {
      ST_IDLE,
      ST_SHIFT
   } engine_state_e;

endpackage

// [sync_two_ff.sv]
// two flip-flop synchroniser for the serial pins
`timescale 1ns/100ps
`include "spi_channel_defines.svh"
module sync_two_ff
   import spi_channel_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [3:0] d_i,
   output logic [3:0] q_o
);

   logic [3:0] stage1;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         stage1 <= `SYNC_RESET;
         q_o <= `SYNC_RESET;
      end else begin
         stage1 <= d_i;
         q_o <= stage1;
      end
   end

endmodule // sync_two_ff

// [serial_clock_gen.sv]
// half-period enable for the master serial clock
`timescale 1ns/100ps
`include "spi_channel_defines.svh"
module serial_clock_gen
   import spi_channel_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic src_sel_i,
   input wire logic timer_i,
   input wire logic run_i,
   output logic tick_o
);

   logic [1:0] div_cnt;
   logic timer_q;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         div_cnt <= 2'h0;
      end else if (!run_i || div_cnt == `DIV_LAST) begin
         div_cnt <= 2'h0;
      end else begin
         div_cnt <= div_cnt + 2'h1;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         timer_q <= 1'b0;
      end else begin
         timer_q <= timer_i;
      end
   end

   // timer output: one half period per rising edge
   assign tick_o = run_i & (src_sel_i ? (timer_i & ~timer_q) : (div_cnt == `DIV_LAST));

endmodule // serial_clock_gen

// [spi_channel_registers.sv]
// serial peripheral channel with apb registers, master and slave engine
`timescale 1ns/100ps
`include "spi_channel_defines.svh"
// Overview of operation
// R1: master role: status bit 2 reads 1 during a transfer, 0 idle.
// R2: slave role: status bit 2 reads 1 while slave select is low.
// R3: status bit 1 read-only, set while a received byte waits, reset 0.
// R4: status bit 0 read-only, 1 when transmit buffer accepts a byte, reset 1.
// R5: 8-bit read/write transmit buffer, reset zero, feeds the shifter.
// R6: each received byte appears in 8-bit read-only receive buffer, reset zero.
// R7: control bit 9 picks timer zero output or peripheral clock divided by four.
// R8: control bit 8: 1 shifts lsb first, 0 msb first, reset msb.
// R9: control bit 5 enables the receive-full interrupt, reset disabled.
// R10: control bit 4 enables the transmit-empty interrupt, reset disabled.
// R11: software sets phase, polarity and role before setting enable.
// R12: interrupt when a buffer flag and its enable are both 1; reserved reads 0.
module spi_channel_registers
   import spi_channel_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [19:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic eight_bit_timer_zero_i,
   output logic sclk_o,
   output logic mosi_o,
   output logic ss_n_o,
   input wire logic miso_i,
   input wire logic sclk_i,
   input wire logic mosi_i,
   input wire logic ss_n_i,
   output logic miso_o,
   output logic miso_oe_o,
   output logic irq_o
);

   function automatic logic addr_is(input logic [19:0] a, input logic [17:0] idx);
      addr_is = (a == {idx, 2'b00});
   endfunction

   function automatic logic [7:0] shift_out(input logic [7:0] v, input logic lsb_first);
      shift_out = lsb_first ? {1'b0, v[7:1]} : {v[6:0], 1'b0};
   endfunction

   function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b, input logic lsb_first);
      shift_in = lsb_first ? {b, v[7:1]} : {v[6:0], b};
   endfunction

   // register state
   logic [`CTL_WIDTH-1:0] control;
   logic [7:0] tx_byte;
   logic [7:0] rx_byte;
   logic tx_empty_flag;
   logic rx_full_flag;
   logic [`EV_WIDTH-1:0] event_status;
   logic [`EV_WIDTH-1:0] event_mask;
   logic [31:0] prdata;

   // engine state
   engine_state_e state;
   logic [3:0] edge_cnt;
   logic [2:0] bit_cnt;
   logic [7:0] tx_shift;
   logic [7:0] rx_shift;
   logic sclk_q;

   // synchronised pins and history
   logic [3:0] pins_sync;
   logic s_sclk;
   logic s_mosi;
   logic s_ss_n;
   logic s_miso;
   logic sclk_prev;
   logic ss_n_prev;

   // control fields
   logic channel_enable;
   logic role_sel;
   logic clock_polarity_sel;
   logic clock_phase_sel;
   logic bit_order_sel;
   logic rx_full_irq_en;
   logic tx_empty_irq_en;
   logic clk_src_sel;

   // decoded strobes and events
   logic wr_acc;
   logic rd_acc;
   logic hit;
   logic tx_wr;
   logic rx_rd;
   logic master_on;
   logic slave_on;
   logic slave_active;
   logic tick;
   logic m_edge;
   logic s_rise;
   logic s_fall;
   logic s_edge;
   logic lead;
   logic edge_ev;
   logic sample_ev;
   logic shift_ev;
   logic byte_done;
   logic rx_samp;
   logic [1:0] m_samp_d;
   logic [1:0] m_last_d;
   logic din;
   logic out_bit;
   logic ss_fall;
   logic master_start;
   logic load_now;
   logic [7:0] load_data;
   logic tx_empty_set;
   logic xfer_busy_or_select_low;
   logic [`EV_WIDTH-1:0] ev_set;
   logic [31:0] read_mux;

   assign channel_enable = control[`CTL_ENABLE_BIT];
   assign role_sel = control[`CTL_ROLE_BIT];
   assign clock_polarity_sel = control[`CTL_POLARITY_BIT];
   assign clock_phase_sel = control[`CTL_PHASE_BIT];
   assign bit_order_sel = control[`CTL_ORDER_BIT];
   assign rx_full_irq_en = control[`CTL_RX_IE_BIT];
   assign tx_empty_irq_en = control[`CTL_TX_IE_BIT];
   assign clk_src_sel = control[`CTL_CLK_SRC_BIT];

   // pins from outside pass two flip-flops first
   sync_two_ff u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i({miso_i, ss_n_i, mosi_i, sclk_i}),
      .q_o(pins_sync)
   );

   assign s_sclk = pins_sync[0];
   assign s_mosi = pins_sync[1];
   assign s_ss_n = pins_sync[2];
   assign s_miso = pins_sync[3];

   assign master_on = channel_enable & role_sel;
   assign slave_on = channel_enable & ~role_sel;
   assign slave_active = slave_on & ~s_ss_n;

   serial_clock_gen u_clk (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .src_sel_i(clk_src_sel), // R7
      .timer_i(eight_bit_timer_zero_i),
      .run_i(master_on && state == ST_SHIFT),
      .tick_o(tick)
   );

   // apb decode, zero wait states
   assign wr_acc = psel_i & penable_i & pwrite_i;
   assign rd_acc = psel_i & penable_i & ~pwrite_i;
   assign hit = addr_is(paddr_i, `IDX_SERIAL_STATUS) | addr_is(paddr_i, `IDX_SERIAL_TX_BUFFER) |
                addr_is(paddr_i, `IDX_SERIAL_RX_BUFFER) | addr_is(paddr_i, `IDX_SERIAL_CONTROL) |
                addr_is(paddr_i, `IDX_EVENT_STATUS) | addr_is(paddr_i, `IDX_EVENT_MASK);
   assign pready_o = 1'b1;
   assign pslverr_o = psel_i & penable_i & ~hit;
   assign prdata_o = prdata;
   assign tx_wr = wr_acc & pstrb_i[0] & addr_is(paddr_i, `IDX_SERIAL_TX_BUFFER);
   assign rx_rd = rd_acc & addr_is(paddr_i, `IDX_SERIAL_RX_BUFFER);

   // serial edge events, master from the clock generator tick (divider or timer), slave from the pin
   assign s_rise = s_sclk & ~sclk_prev;
   assign s_fall = ~s_sclk & sclk_prev;
   assign ss_fall = ~s_ss_n & ss_n_prev;
   assign m_edge = master_on & (state == ST_SHIFT) & tick;
   assign s_edge = slave_active & (s_rise | s_fall);
   assign lead = master_on ? (sclk_q == clock_polarity_sel) : (clock_polarity_sel ? s_fall : s_rise);
   assign edge_ev = m_edge | s_edge;
   assign sample_ev = edge_ev & (lead ^ clock_phase_sel);
   assign shift_ev = edge_ev & ~(lead ^ clock_phase_sel) & (bit_cnt != 3'h0);
   // master input lags two cycles in the synchroniser, so it is taken two cycles late
   assign rx_samp = master_on ? m_samp_d[1] : sample_ev;
   assign byte_done = master_on ? (m_samp_d[1] & m_last_d[1]) : (sample_ev & (bit_cnt == `LAST_BIT));
   assign din = master_on ? s_miso : s_mosi;
   assign out_bit = bit_order_sel ? tx_shift[0] : tx_shift[7]; // R8

   // loading the shifter takes the waiting byte
   assign master_start = master_on & (state == ST_IDLE) & ~tx_empty_flag & ~tx_wr;
   assign load_now = master_start | (slave_on & (ss_fall | (byte_done & slave_active)));
   assign load_data = tx_wr ? pwdata_i[7:0] : tx_byte;
   assign tx_empty_set = load_now & (~tx_empty_flag | tx_wr);

   assign xfer_busy_or_select_low = role_sel ? (state == ST_SHIFT) : ~s_ss_n; // R1 R2

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         control <= `CTL_RESET;
      end else if (wr_acc && addr_is(paddr_i, `IDX_SERIAL_CONTROL)) begin
         if (pstrb_i[0]) begin
            control[7:0] <= pwdata_i[7:0] & 8'(`CTL_WRITE_MASK);
         end
         if (pstrb_i[1]) begin
            control[9:8] <= pwdata_i[9:8];
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_byte <= `TX_BYTE_RESET;
      end else if (tx_wr) begin
         tx_byte <= pwdata_i[7:0]; // R5
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_empty_flag <= `TX_EMPTY_RESET;
      end else if (tx_empty_set) begin
         tx_empty_flag <= 1'b1; // R4
      end else if (tx_wr) begin
         tx_empty_flag <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_shift <= `TX_BYTE_RESET;
      end else if (load_now) begin
         tx_shift <= load_data; // R5
      end else if (shift_ev) begin
         tx_shift <= shift_out(tx_shift, bit_order_sel); // R8
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_shift <= `RX_BYTE_RESET;
      end else if (rx_samp) begin
         rx_shift <= shift_in(rx_shift, din, bit_order_sel); // R8
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         m_samp_d <= 2'h0;
         m_last_d <= 2'h0;
      end else begin
         m_samp_d <= {m_samp_d[0], sample_ev & master_on};
         m_last_d <= {m_last_d[0], bit_cnt == `LAST_BIT};
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         bit_cnt <= 3'h0;
      end else if (!channel_enable || (slave_on && s_ss_n) || master_start) begin
         bit_cnt <= 3'h0;
      end else if (sample_ev) begin
         bit_cnt <= bit_cnt + 3'h1;
      end
   end

   // master sequencer: sixteen half periods per byte
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state <= ST_IDLE;
         edge_cnt <= 4'h0;
      end else if (!master_on) begin
         state <= ST_IDLE;
         edge_cnt <= 4'h0;
      end else begin
         unique case (state)
            ST_IDLE: begin
               edge_cnt <= 4'h0;
               if (master_start) begin
                  state <= ST_SHIFT; // R1
               end
            end
            ST_SHIFT: begin
               if (m_edge) begin
                  edge_cnt <= edge_cnt + 4'h1;
                  if (edge_cnt == `LAST_EDGE) begin
                     state <= ST_IDLE; // R1
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sclk_q <= 1'b0;
      end else if (!(master_on && state == ST_SHIFT)) begin
         sclk_q <= clock_polarity_sel;
      end else if (m_edge) begin
         sclk_q <= ~sclk_q;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sclk_prev <= 1'b0;
         ss_n_prev <= 1'b1;
      end else begin
         sclk_prev <= s_sclk;
         ss_n_prev <= s_ss_n;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_byte <= `RX_BYTE_RESET;
      end else if (byte_done) begin
         rx_byte <= shift_in(rx_shift, din, bit_order_sel); // R6
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_full_flag <= 1'b0;
      end else if (byte_done) begin
         rx_full_flag <= 1'b1; // R3
      end else if (rx_rd) begin
         rx_full_flag <= 1'b0;
      end
   end

   // sticky events, set wins over a write-one clear
   always_comb begin
      ev_set = `EV_RESET;
      ev_set[`EV_TX_EMPTY_BIT] = tx_empty_set;
      ev_set[`EV_RX_FULL_BIT] = byte_done;
      ev_set[`EV_OVERRUN_BIT] = byte_done & rx_full_flag & ~rx_rd;
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         event_status <= `EV_RESET;
      end else if (wr_acc && pstrb_i[0] && addr_is(paddr_i, `IDX_EVENT_STATUS)) begin
         event_status <= (event_status & ~pwdata_i[`EV_WIDTH-1:0]) | ev_set;
      end else begin
         event_status <= event_status | ev_set;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         event_mask <= `EV_RESET;
      end else if (wr_acc && pstrb_i[0] && addr_is(paddr_i, `IDX_EVENT_MASK)) begin
         event_mask <= pwdata_i[`EV_WIDTH-1:0];
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= (rx_full_flag & rx_full_irq_en) | (tx_empty_flag & tx_empty_irq_en) | // R9 R10 R12
                  (|(event_status & event_mask));
      end
   end

   // read data, reserved bits zero
   always_comb begin
      read_mux = 32'h0000_0000;
      if (addr_is(paddr_i, `IDX_SERIAL_STATUS)) begin
         read_mux[`ST_BUSY_BIT] = xfer_busy_or_select_low;
         read_mux[`ST_RX_FULL_BIT] = rx_full_flag; // R3
         read_mux[`ST_TX_EMPTY_BIT] = tx_empty_flag; // R4
      end else if (addr_is(paddr_i, `IDX_SERIAL_TX_BUFFER)) begin
         read_mux[7:0] = tx_byte;
      end else if (addr_is(paddr_i, `IDX_SERIAL_RX_BUFFER)) begin
         read_mux[7:0] = rx_byte; // R6
      end else if (addr_is(paddr_i, `IDX_SERIAL_CONTROL)) begin
         read_mux[`CTL_WIDTH-1:0] = control; // R12
      end else if (addr_is(paddr_i, `IDX_EVENT_STATUS)) begin
         read_mux[`EV_WIDTH-1:0] = event_status;
      end else if (addr_is(paddr_i, `IDX_EVENT_MASK)) begin
         read_mux[`EV_WIDTH-1:0] = event_mask;
      end
   end

   // captured in the setup cycle, stable through the access cycle
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         prdata <= 32'h0000_0000;
      end else if (psel_i && !penable_i && !pwrite_i) begin
         prdata <= read_mux;
      end
   end

   // serial pins
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ss_n_o <= 1'b1;
      end else begin
         ss_n_o <= ~(master_on & (master_start | (state == ST_SHIFT)));
      end
   end

   assign sclk_o = sclk_q;
   assign mosi_o = master_on & out_bit;
   assign miso_o = slave_active & out_bit;
   assign miso_oe_o = slave_active;

endmodule // spi_channel_registers

// [spi_far_device.sv]
// far-side serial device answering the channel master in mode zero
`timescale 1ns/100ps
module spi_far_device (
   input wire logic sclk_i,
   input wire logic ss_n_i,
   input wire logic mosi_i,
   input wire logic lsb_first_i,
   input wire logic [7:0] reply_i,
   output logic miso_o,
   output logic [7:0] got_o
);
   int tx_idx = 0;
   int rx_idx = 0;
   initial miso_o = 1'b0;
   initial got_o = 8'h00;
   // first bit valid before the leading edge
   always @(negedge ss_n_i) begin
      tx_idx = 0;
      rx_idx = 0;
      miso_o = reply_i[lsb_first_i ? 0 : 7];
   end
   always @(posedge sclk_i) begin
      if (!ss_n_i && rx_idx < 8) begin
         got_o[lsb_first_i ? rx_idx : 7 - rx_idx] = mosi_i;
         rx_idx++;
      end
   end
   // next bit on the trailing edge, held a full period
   always @(negedge sclk_i) begin
      if (!ss_n_i && tx_idx < 7) begin
         tx_idx++;
         miso_o = reply_i[lsb_first_i ? tx_idx : 7 - tx_idx];
      end
   end
   // released line has no pull, so show the inverse
   always @(posedge ss_n_i) miso_o = ~miso_o;
endmodule // spi_far_device

// [spi_channel_registers_monitor.sv]
// concurrent checks on the serial channel ports
`timescale 1ns/100ps
`include "spi_channel_defines.svh"
module spi_channel_registers_monitor (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [19:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic eight_bit_timer_zero_i,
   input wire logic sclk_o,
   input wire logic mosi_o,
   input wire logic ss_n_o,
   input wire logic miso_i,
   input wire logic sclk_i,
   input wire logic mosi_i,
   input wire logic ss_n_i,
   input wire logic miso_o,
   input wire logic miso_oe_o,
   input wire logic irq_o
);
   logic [4:0] edge_cnt;
   logic sclk_q;
   logic ss_q;
   function automatic logic [31:0] rmask(input logic [19:0] a);
      rmask = 32'h0;
      if (a[1:0] == 2'h0) begin
         case (a[19:2])
            `IDX_SERIAL_STATUS: rmask = 32'h7;
            `IDX_SERIAL_TX_BUFFER, `IDX_SERIAL_RX_BUFFER: rmask = 32'hff;
            `IDX_SERIAL_CONTROL: rmask = 32'h33f;
            `IDX_EVENT_STATUS, `IDX_EVENT_MASK: rmask = 32'h7;
            default: rmask = 32'h0;
         endcase
      end
   endfunction
   // serial clock edges seen within one frame
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         edge_cnt <= 5'h0;
         sclk_q <= 1'b0;
         ss_q <= 1'b1;
      end else begin
         sclk_q <= sclk_o;
         ss_q <= ss_n_o;
         if (ss_n_o && ss_q) begin
            edge_cnt <= 5'h0;
         end else if (sclk_o != sclk_q) begin
            edge_cnt <= edge_cnt + 5'h1;
         end
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   chk_unmapped_err: assert property (psel_i && penable_i && rmask(paddr_i) == 32'h0 |-> pslverr_o)
      else $error("unmapped access without error");
   chk_mapped_no_err: assert property (psel_i && penable_i && rmask(paddr_i) != 32'h0 |-> !pslverr_o)
      else $error("mapped access flagged as error");
   chk_unmapped_zero: assert property (psel_i && penable_i && !pwrite_i && rmask(paddr_i) == 32'h0 |-> prdata_o == 32'h0)
      else $error("unmapped read not zero");
   chk_reserved_zero: assert property (psel_i && penable_i && !pwrite_i |-> (prdata_o & ~rmask(paddr_i)) == 32'h0)
      else $error("reserved read bits not zero");
   chk_read_hold: assert property (!(psel_i && !penable_i && !pwrite_i) |=> $stable(prdata_o))
      else $error("read data changed outside a read setup");
   chk_byte_edges: assert property ($rose(ss_n_o) |=> edge_cnt == 5'h10)
      else $error("frame without sixteen serial clock edges");
   chk_frame_len: assert property ($fell(ss_n_o) |-> !ss_n_o [*8])
      else $error("select frame too short");
   chk_miso_quiet: assert property (ss_n_i [*5] |-> !miso_oe_o && !miso_o)
      else $error("slave output active while not selected");
endmodule // spi_channel_registers_monitor
bind spi_channel_registers spi_channel_registers_monitor u_monitor (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
   .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .eight_bit_timer_zero_i(eight_bit_timer_zero_i),
   .sclk_o(sclk_o), .mosi_o(mosi_o), .ss_n_o(ss_n_o), .miso_i(miso_i), .sclk_i(sclk_i), .mosi_i(mosi_i),
   .ss_n_i(ss_n_i), .miso_o(miso_o), .miso_oe_o(miso_oe_o), .irq_o(irq_o));

// [spi_channel_registers_test.sv]
// self-checking bench for the serial channel registers
`timescale 1ns/100ps
`include "spi_channel_defines.svh"
`define CHECK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin err_total++; \
   $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module spi_channel_registers_test;
   localparam logic [19:0] a_st = {`IDX_SERIAL_STATUS, 2'h0};
   localparam logic [19:0] a_tx = {`IDX_SERIAL_TX_BUFFER, 2'h0};
   localparam logic [19:0] a_rx = {`IDX_SERIAL_RX_BUFFER, 2'h0};
   localparam logic [19:0] a_ctl = {`IDX_SERIAL_CONTROL, 2'h0};
   localparam logic [19:0] a_ev = {`IDX_EVENT_STATUS, 2'h0};
   localparam logic [19:0] a_msk = {`IDX_EVENT_MASK, 2'h0};
   logic clk_i = 1'b0, rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
   logic [19:0] paddr_i = 20'h0;
   logic [31:0] pwdata_i = 32'h0, prdata_o, v;
   logic pready_o, pslverr_o, last_err, sclk_o, mosi_o, ss_n_o, miso, miso_o, miso_oe_o, irq_o;
   logic tmr_i = 1'b0, ss_n_i = 1'b1, lsb = 1'b0;
   logic [1:0] tmr = 2'h0;
   logic [7:0] reply = 8'h0, got;
   int err_total = 0, comparisons = 0, seed, i;
   spi_channel_registers u_dut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(4'hf), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .eight_bit_timer_zero_i(tmr_i), .sclk_o(sclk_o),
      .mosi_o(mosi_o), .ss_n_o(ss_n_o), .miso_i(miso), .sclk_i(1'b0), .mosi_i(1'b0), .ss_n_i(ss_n_i),
      .miso_o(miso_o), .miso_oe_o(miso_oe_o), .irq_o(irq_o));
   spi_far_device u_far (.sclk_i(sclk_o), .ss_n_i(ss_n_o), .mosi_i(mosi_o), .lsb_first_i(lsb),
      .reply_i(reply), .miso_o(miso), .got_o(got));
   initial forever #5 clk_i = ~clk_i;
   // timer output rises every fourth cycle
   always @(posedge clk_i) begin
      tmr <= tmr + 2'h1;
      tmr_i <= tmr[1];
   end
   task automatic print_verdict();
      $display("errors %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic apb(input logic [19:0] a, input logic w, input logic [31:0] d, output logic [31:0] rd);
      int n;
      @(posedge clk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 20);
      if (n >= 20) begin
         err_total++;
         print_verdict();
      end
      rd = prdata_o;
      last_err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   task automatic wr(input logic [19:0] a, input logic [31:0] d);
      logic [31:0] x;
      apb(a, 1'b1, d, x);
   endtask
   task automatic rd_chk(input string nm, input logic [19:0] a, input logic [31:0] exp);
      logic [31:0] x;
      apb(a, 1'b0, 32'h0, x);
      `CHECK(nm, exp, x)
   endtask
   function automatic logic [31:0] ctl_seen(input logic [31:0] w);
      return w & {22'h0, `CTL_WRITE_MASK};
   endfunction
   task automatic xfer(input logic order, input logic src);
      logic [31:0] c, t, x;
      int n;
      c = {22'h0, src, order, 8'h22};
      t = $urandom() & 32'hff;
      reply = 8'($urandom());
      lsb = order;
      wr(a_ctl, c);
      wr(a_ctl, c | 32'h1);
      wr(a_tx, t);
      repeat (3) @(posedge clk_i);
      rd_chk("busy status", a_st, 32'h5);
      n = 0;
      do begin
         apb(a_st, 1'b0, 32'h0, x);
         n++;
      end while (x[2] !== 1'b0 && n < 100);
      `CHECK("done status", 32'h3, x)
      repeat (2) @(posedge clk_i);
      `CHECK("irq rx full", 1'b1, irq_o)
      rd_chk("rx data", a_rx, {24'h0, reply});
      `CHECK("mosi data", t[7:0], got)
      repeat (2) @(posedge clk_i);
      `CHECK("irq rx read", 1'b0, irq_o)
      rd_chk("status after read", a_st, 32'h1);
   endtask
   initial begin
      seed = $urandom(788);
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      rd_chk("status reset", a_st, 32'h1);
      rd_chk("tx reset", a_tx, 32'h0);
      rd_chk("rx reset", a_rx, 32'h0);
      rd_chk("control reset", a_ctl, 32'h0);
      rd_chk("unmapped", 20'h10cb0, 32'h0);
      `CHECK("unmapped error", 1'b1, last_err)
      wr(a_st, 32'hffff);
      rd_chk("status read only", a_st, 32'h1);
      wr(a_rx, 32'hffff);
      rd_chk("rx read only", a_rx, 32'h0);
      for (i = 0; i < 4; i++) begin
         v = $urandom() & 32'hfffe;
         wr(a_ctl, v);
         rd_chk("control", a_ctl, ctl_seen(v));
      end
      wr(a_ctl, 32'h10);
      repeat (2) @(posedge clk_i);
      `CHECK("irq tx empty", 1'b1, irq_o)
      wr(a_ctl, 32'h0);
      repeat (2) @(posedge clk_i);
      `CHECK("irq tx masked", 1'b0, irq_o)
      for (i = 0; i < 4; i++) xfer(i[0], i[1]);
      rd_chk("events", a_ev, 32'h3);
      wr(a_msk, 32'h2);
      repeat (2) @(posedge clk_i);
      `CHECK("irq event", 1'b1, irq_o)
      wr(a_ev, 32'h2);
      repeat (2) @(posedge clk_i);
      `CHECK("irq event cleared", 1'b0, irq_o)
      rd_chk("events cleared", a_ev, 32'h1);
      wr(a_msk, 32'h0);
      wr(a_ctl, 32'h0);
      ss_n_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      rd_chk("select low", a_st, 32'h5);
      ss_n_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rd_chk("select high", a_st, 32'h1);
      print_verdict();
   end
   initial begin
      #500000;
      err_total++;
      print_verdict();
   end
endmodule // spi_channel_registers_test
